//--- inc/ofspl_pkg.sv
// Constants, register map and carrier types of the output function selector
// and parameter lock block. Assumes one 100 MHz clock and AXI4-Lite access.
//
// Function
// RULE_01: Selector holds 0..12 documented, default 8, and also recognises 13.
// RULE_02: Setting 0 drives output high while motor enabled and running.
// RULE_03: Setting 1 drives output high while no fault is present.
// RULE_04: Setting 2 drives output high when output frequency equals setpoint.
// RULE_05: Setting 3 drives output high while the drive is tripped.
// RULE_06: Setting 4 drives output high when frequency is at or above threshold.
// RULE_07: Setting 5 drives output high when current is at or above threshold.
// RULE_08: Settings 6 and 7 are high while frequency or current is below threshold.
// RULE_09: Setting 8 gives analog speed, zero to maximum frequency, 0.1 Hz steps.
// RULE_10: Setting 9 gives analog current, zero to 200% of rated current.
// RULE_11: Setting 10 gives analog power, zero to 200% of rated drive power.
// RULE_12: Setting 11 gives analog torque, zero to 200% of rated current.
// RULE_13: Setting 12 copies bit 9 of the first fieldbus word to the output.
// RULE_14: Setting 13 drives analog level from the third fieldbus word.
// RULE_15: Comparison threshold holds 0.0 to 200.0 percent, default 100.0.
// RULE_16: Access entry 0..65535, default 0; code opens extended, code+100 advanced.
// RULE_17: Access code 0..9999, default 101; later parameters hidden unless entry matches.
// RULE_18: Lock 0 allows writes; lock 1 rejects all writes except the lock itself.
// RULE_19: Out of range writes are rejected and the stored value stays unchanged.

package ofspl_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_SELECT = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_ENTRY = 8'h08;
    localparam logic [7:0] OFS_CODE = 8'h0c;
    localparam logic [7:0] OFS_LOCK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [3:0] SELECT_RST = 4'h8;
    localparam logic [3:0] SELECT_MAX = 4'hd;
    localparam logic [15:0] THRESH_RST = 16'h03e8;
    localparam logic [15:0] THRESH_MAX = 16'h07d0;
    localparam logic [15:0] ENTRY_RST = 16'h0000;
    localparam logic [15:0] CODE_RST = 16'h0065;
    localparam logic [15:0] CODE_MAX = 16'h270f;
    localparam logic [15:0] ADV_OFFSET = 16'h0064;
    localparam logic LOCK_RST = 1'b0;
    localparam int STATUS_LEVEL_BIT = 12;
    localparam int STATUS_ANALOG_BIT = 13;
    localparam int STATUS_EXT_BIT = 14;
    localparam int STATUS_ADV_BIT = 15;
    localparam int FB_DIGITAL_BIT = 9;

    // ************************************************************
    // Selector codes and scaling
    // ************************************************************
    localparam logic [3:0] SEL_RUNNING = 4'h0;
    localparam logic [3:0] SEL_HEALTHY = 4'h1;
    localparam logic [3:0] SEL_AT_SPEED = 4'h2;
    localparam logic [3:0] SEL_TRIPPED = 4'h3;
    localparam logic [3:0] SEL_FREQ_GE = 4'h4;
    localparam logic [3:0] SEL_CUR_GE = 4'h5;
    localparam logic [3:0] SEL_FREQ_LT = 4'h6;
    localparam logic [3:0] SEL_CUR_LT = 4'h7;
    localparam logic [3:0] SEL_SPEED = 4'h8;
    localparam logic [3:0] SEL_CURRENT = 4'h9;
    localparam logic [3:0] SEL_POWER = 4'ha;
    localparam logic [3:0] SEL_TORQUE = 4'hb;
    localparam logic [3:0] SEL_FB_DIG = 4'hc;
    localparam logic [3:0] SEL_FB_ANA = 4'hd;
    localparam logic [11:0] ANALOG_FULL = 12'hfff;
    localparam logic [31:0] PCT_UNITY = 32'h0000_03e8;
    localparam logic [16:0] POWER_FULL = 17'h007d0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic running;
        logic fault;
        logic at_speed;
        logic tripped;
        logic [15:0] speed_dhz;
        logic [15:0] max_dhz;
        logic [15:0] cur_da;
        logic [15:0] rated_da;
        logic [15:0] torque_da;
        logic [15:0] power_pm;
    } ofspl_drive_s;

    typedef struct packed {
        logic [15:0] fieldbus_word_first;
        logic [15:0] fieldbus_word_third;
    } ofspl_fbus_s;

endpackage

//--- core/ofspl_core.sv
// Output function selector and parameter access lock with AXI4-Lite slave.
// Assumes drive status and fieldbus words arrive from logic on clk.

`timescale 1ns/1ns
`default_nettype none

module ofspl_core (
    input wire logic clk, // 100 MHz
    input wire logic srst, // Synchronous reset, high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire ofspl_pkg::ofspl_drive_s drive, // Drive status
    input wire ofspl_pkg::ofspl_fbus_s fbus, // Fieldbus process words
    output logic out_level, // Digital terminal level
    output logic [11:0] out_analog, // Analog terminal level
    output logic out_analog_mode, // Terminal in analog mode
    output logic ext_access_open, // Extended group open
    output logic adv_access_open // Advanced group open
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [3:0] sel_r;
    logic [15:0] thresh_r;
    logic [15:0] entry_r;
    logic [15:0] code_r;
    logic lock_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic out_level_r;
    logic [11:0] out_analog_r;
    logic analog_mode_r;
    logic ext_open_r;
    logic adv_open_r;

    logic wr_go;
    logic [31:0] wr_cur;
    logic [31:0] wr_val;
    logic wr_mapped;
    logic wr_ok;
    logic freq_ge;
    logic cur_ge;
    logic level_nxt;
    logic [11:0] analog_nxt;
    logic visible;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Scale num to full analog range at den; clamps, zero den gives zero
    function automatic logic [11:0] scale(input logic [15:0] num, input logic [16:0] den);
        logic [31:0] q;
        q = 32'h0;
        if (den != 17'h0) begin
            q = (32'(num) * 32'(ofspl_pkg::ANALOG_FULL)) / 32'(den);
        end
        if (q > 32'(ofspl_pkg::ANALOG_FULL)) begin
            q = 32'(ofspl_pkg::ANALOG_FULL);
        end
        return q[11:0];
    endfunction

    // Read view of a register; hidden ones read zero
    function automatic logic [31:0] reg_view(input logic [7:0] a, input logic vis);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            ofspl_pkg::OFS_SELECT: v = vis ? 32'(sel_r) : 32'h0;
            ofspl_pkg::OFS_THRESH: v = vis ? 32'(thresh_r) : 32'h0;
            ofspl_pkg::OFS_ENTRY: v = 32'(entry_r);
            ofspl_pkg::OFS_CODE: v = vis ? 32'(code_r) : 32'h0;
            ofspl_pkg::OFS_LOCK: v = vis ? 32'(lock_r) : 32'h0;
            ofspl_pkg::OFS_STATUS: begin
                v[11:0] = out_analog_r;
                v[ofspl_pkg::STATUS_LEVEL_BIT] = out_level_r;
                v[ofspl_pkg::STATUS_ANALOG_BIT] = analog_mode_r;
                v[ofspl_pkg::STATUS_EXT_BIT] = ext_open_r;
                v[ofspl_pkg::STATUS_ADV_BIT] = adv_open_r;
            end
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == ofspl_pkg::OFS_SELECT || a == ofspl_pkg::OFS_THRESH ||
            a == ofspl_pkg::OFS_ENTRY || a == ofspl_pkg::OFS_CODE ||
            a == ofspl_pkg::OFS_LOCK || a == ofspl_pkg::OFS_STATUS;
    endfunction

    assign visible = ext_open_r | adv_open_r; // RULE_17

    // ************************************************************
    // AXI4-Lite write channels
    // ************************************************************
    // Address and data latch independently; commit once both are held
    assign wr_go = !awready_r && !wready_r && !bvalid_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            awready_r <= 1'b1;
            aw_addr_r <= 8'h0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wready_r <= 1'b1;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    // Merge strobed lanes into the current value before the range check
    always_comb begin
        wr_cur = reg_view(aw_addr_r, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr_val[8*i +: 8] = w_strb_r[i] ? w_data_r[8*i +: 8] : wr_cur[8*i +: 8];
        end
        wr_mapped = mapped(aw_addr_r) && aw_addr_r != ofspl_pkg::OFS_STATUS;
        case (aw_addr_r)
            ofspl_pkg::OFS_SELECT: wr_ok = visible && !lock_r && wr_val <= 32'(ofspl_pkg::SELECT_MAX); // RULE_19
            ofspl_pkg::OFS_THRESH: wr_ok = visible && !lock_r && wr_val <= 32'(ofspl_pkg::THRESH_MAX); // RULE_19
            ofspl_pkg::OFS_ENTRY: wr_ok = !lock_r && wr_val[31:16] == 16'h0; // RULE_18
            ofspl_pkg::OFS_CODE: wr_ok = visible && !lock_r && wr_val <= 32'(ofspl_pkg::CODE_MAX); // RULE_19
            ofspl_pkg::OFS_LOCK: wr_ok = visible && wr_val[31:1] == 31'h0; // RULE_18
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_r <= 1'b0;
            bresp_r <= ofspl_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= !wr_mapped ? ofspl_pkg::RESP_DECERR :
                wr_ok ? ofspl_pkg::RESP_OKAY : ofspl_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // Parameter registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_r <= ofspl_pkg::SELECT_RST; // RULE_01
            thresh_r <= ofspl_pkg::THRESH_RST; // RULE_15
            entry_r <= ofspl_pkg::ENTRY_RST;
            code_r <= ofspl_pkg::CODE_RST; // RULE_17
            lock_r <= ofspl_pkg::LOCK_RST;
        end else if (wr_go && wr_ok) begin
            case (aw_addr_r)
                ofspl_pkg::OFS_SELECT: sel_r <= wr_val[3:0]; // RULE_01
                ofspl_pkg::OFS_THRESH: thresh_r <= wr_val[15:0]; // RULE_15
                ofspl_pkg::OFS_ENTRY: entry_r <= wr_val[15:0]; // RULE_16
                ofspl_pkg::OFS_CODE: code_r <= wr_val[15:0]; // RULE_17
                ofspl_pkg::OFS_LOCK: lock_r <= wr_val[0]; // RULE_18
                default: lock_r <= lock_r;
            endcase
        end
    end

    // Advanced entry compare is 17 bits so code plus offset cannot wrap; extended compare is 16 bits
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_open_r <= 1'b0;
            adv_open_r <= 1'b0;
        end else begin
            ext_open_r <= entry_r == code_r; // RULE_16
            adv_open_r <= 17'(entry_r) == 17'(code_r) + 17'(ofspl_pkg::ADV_OFFSET); // RULE_16
        end
    end

    // ************************************************************
    // AXI4-Lite read channels
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= ofspl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= reg_view(s_axi_araddr, visible); // RULE_17
            rresp_r <= !mapped(s_axi_araddr) ? ofspl_pkg::RESP_DECERR : ofspl_pkg::RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // Output function
    // ************************************************************
    // Cross-multiplied percent compare avoids a divider; threshold is 0.1 %
    assign freq_ge = 32'(drive.speed_dhz) * ofspl_pkg::PCT_UNITY >= 32'(thresh_r) * 32'(drive.max_dhz);
    assign cur_ge = 32'(drive.cur_da) * ofspl_pkg::PCT_UNITY >= 32'(thresh_r) * 32'(drive.rated_da);

    always_comb begin
        level_nxt = 1'b0;
        analog_nxt = 12'h0;
        case (sel_r)
            ofspl_pkg::SEL_RUNNING: level_nxt = drive.running; // RULE_02
            ofspl_pkg::SEL_HEALTHY: level_nxt = !drive.fault; // RULE_03
            ofspl_pkg::SEL_AT_SPEED: level_nxt = drive.at_speed; // RULE_04
            ofspl_pkg::SEL_TRIPPED: level_nxt = drive.tripped; // RULE_05
            ofspl_pkg::SEL_FREQ_GE: level_nxt = freq_ge; // RULE_06
            ofspl_pkg::SEL_CUR_GE: level_nxt = cur_ge; // RULE_07
            ofspl_pkg::SEL_FREQ_LT: level_nxt = !freq_ge; // RULE_08
            ofspl_pkg::SEL_CUR_LT: level_nxt = !cur_ge; // RULE_08
            ofspl_pkg::SEL_SPEED: analog_nxt = scale(drive.speed_dhz, 17'(drive.max_dhz)); // RULE_09
            ofspl_pkg::SEL_CURRENT: analog_nxt = scale(drive.cur_da, {drive.rated_da, 1'b0}); // RULE_10
            ofspl_pkg::SEL_POWER: analog_nxt = scale(drive.power_pm, ofspl_pkg::POWER_FULL); // RULE_11
            ofspl_pkg::SEL_TORQUE: analog_nxt = scale(drive.torque_da, {drive.rated_da, 1'b0}); // RULE_12
            ofspl_pkg::SEL_FB_DIG: level_nxt = fbus.fieldbus_word_first[ofspl_pkg::FB_DIGITAL_BIT]; // RULE_13
            ofspl_pkg::SEL_FB_ANA: begin
                // Values above 4095 clamp to the widest code
                analog_nxt = fbus.fieldbus_word_third > 16'(ofspl_pkg::ANALOG_FULL) ?
                    ofspl_pkg::ANALOG_FULL : fbus.fieldbus_word_third[11:0]; // RULE_14
            end
            default: level_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_level_r <= 1'b0;
            out_analog_r <= 12'h0;
            analog_mode_r <= 1'b1;
        end else begin
            out_level_r <= level_nxt;
            out_analog_r <= analog_nxt;
            analog_mode_r <= (sel_r >= ofspl_pkg::SEL_SPEED && sel_r <= ofspl_pkg::SEL_TORQUE) ||
                sel_r == ofspl_pkg::SEL_FB_ANA;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign out_level = out_level_r;
    assign out_analog = out_analog_r;
    assign out_analog_mode = analog_mode_r;
    assign ext_access_open = ext_open_r;
    assign adv_access_open = adv_open_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_sel_in_range: assert property (@(posedge clk) disable iff (srst) // RULE_01
        sel_r <= ofspl_pkg::SELECT_MAX) else $error("selector outside range");

    a_run_level: assert property (@(posedge clk) disable iff (srst) // RULE_02
        sel_r == ofspl_pkg::SEL_RUNNING && $stable(sel_r) |=> out_level_r == $past(drive.running))
        else $error("running level wrong");

    a_healthy_level: assert property (@(posedge clk) disable iff (srst) // RULE_03
        sel_r == ofspl_pkg::SEL_HEALTHY |=> out_level_r == !$past(drive.fault))
        else $error("healthy level wrong");

    a_speed_level: assert property (@(posedge clk) disable iff (srst) // RULE_04
        sel_r == ofspl_pkg::SEL_AT_SPEED |=> out_level_r == $past(drive.at_speed))
        else $error("at speed level wrong");

    a_trip_level: assert property (@(posedge clk) disable iff (srst) // RULE_05
        sel_r == ofspl_pkg::SEL_TRIPPED |=> out_level_r == $past(drive.tripped))
        else $error("trip level wrong");

    a_freq_compare: assert property (@(posedge clk) disable iff (srst) // RULE_06
        sel_r == ofspl_pkg::SEL_FREQ_GE
        && 32'(drive.speed_dhz) * 32'h0000_03e8 >= 32'(thresh_r) * 32'(drive.max_dhz)
        |=> out_level_r) else $error("frequency compare wrong");

    a_cur_below: assert property (@(posedge clk) disable iff (srst) // RULE_08
        sel_r == ofspl_pkg::SEL_CUR_LT && drive.rated_da != 16'h0
        && 32'(drive.cur_da) * 32'h0000_03e8 < 32'(thresh_r) * 32'(drive.rated_da)
        |=> out_level_r) else $error("current below compare wrong");

    a_fb_digital: assert property (@(posedge clk) disable iff (srst) // RULE_13
        sel_r == ofspl_pkg::SEL_FB_DIG |=> out_level_r == $past(fbus.fieldbus_word_first[9])
        && !analog_mode_r) else $error("fieldbus digital wrong");

    a_fb_analog: assert property (@(posedge clk) disable iff (srst) // RULE_14
        sel_r == ofspl_pkg::SEL_FB_ANA && fbus.fieldbus_word_third < 16'h0fff
        |=> out_analog_r == $past(fbus.fieldbus_word_third[11:0]) && analog_mode_r)
        else $error("fieldbus analog wrong");

    a_speed_full: assert property (@(posedge clk) disable iff (srst) // RULE_09
        sel_r == ofspl_pkg::SEL_SPEED && drive.speed_dhz == drive.max_dhz && drive.max_dhz != 16'h0
        |=> out_analog_r == 12'hfff) else $error("speed full scale wrong");

    a_access_open: assert property (@(posedge clk) disable iff (srst) // RULE_16
        entry_r == code_r && $stable(entry_r) && $stable(code_r) |=> ext_open_r)
        else $error("extended access not opened");

    a_lock_holds: assert property (@(posedge clk) disable iff (srst) // RULE_18
        wr_go && lock_r && aw_addr_r != ofspl_pkg::OFS_LOCK
        |=> $stable(sel_r) && $stable(thresh_r) && $stable(entry_r) && $stable(code_r)
        && bresp_r != ofspl_pkg::RESP_OKAY) else $error("locked write changed a value");

    a_code_range: assert property (@(posedge clk) disable iff (srst) // RULE_19
        wr_go && aw_addr_r == ofspl_pkg::OFS_CODE && wr_val > 32'h0000_270f
        |=> $stable(code_r) ##0 bvalid_r) else $error("out of range code stored");

    a_hidden_read: assert property (@(posedge clk) disable iff (srst) // RULE_17
        s_axi_arvalid && arready_r && !visible && s_axi_araddr == ofspl_pkg::OFS_SELECT
        |=> rvalid_r && rdata_r == 32'h0) else $error("hidden register readable");

endmodule

`default_nettype wire

//--- testbench/ofspl_plant_model.sv
// Plant-side reader of the output terminal: samples its level and analog value.
// Assumes the plant samples on the drive's own clock.
`timescale 1ns/1ns
`default_nettype none
module ofspl_plant_model (
    input wire logic clk, // Sampling clock
    input wire logic srst, // Synchronous reset, high
    input wire logic out_level, // Digital terminal
    input wire logic [11:0] out_analog, // Analog terminal
    input wire logic out_analog_mode, // Terminal mode
    output logic seen_level, // Level as read
    output logic [11:0] seen_analog // Value as read
);
    // ************************************************************
    // Sampling
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            seen_level <= 1'b0;
            seen_analog <= 12'h000;
        end else begin
            seen_level <= out_level;
            // Analog input reads nothing while the terminal is digital
            seen_analog <= out_analog_mode ? out_analog : 12'h000;
        end
    end
endmodule
`default_nettype wire

//--- testbench/ofspl_core_tb_top.sv
// Bench for the output selector and access lock, via AXI4-Lite tasks.
// Assumes ofspl_pkg and the plant model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module ofspl_core_tb_top;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ofspl_pkg::ofspl_drive_s drive = '0;
    ofspl_pkg::ofspl_fbus_s fbus = '0;
    logic out_level, out_analog_mode, ext_access_open, adv_access_open, seen_level;
    logic [11:0] out_analog, seen_analog;
    int n_errors = 0, comparisons = 0, cyc = 0;
    ofspl_core dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive, .fbus, .out_level,
        .out_analog, .out_analog_mode, .ext_access_open, .adv_access_open);
    ofspl_plant_model plant (.clk, .srst, .out_level, .out_analog, .out_analog_mode, .seen_level, .seen_analog);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_pin(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_reg("bresp", {30'h0, exp}, {30'h0, s_axi_bresp});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] exp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk_reg("rresp", {30'h0, exp}, {30'h0, s_axi_rresp});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, ofspl_pkg::RESP_OKAY);
        chk_reg("rdata", exp, rd);
    endtask
    task automatic pin_chk(input logic [3:0] sel, input logic lvl, input logic [11:0] ana);
        axi_wr(ofspl_pkg::OFS_SELECT, {28'h0, sel}, ofspl_pkg::RESP_OKAY);
        repeat (3) @(posedge clk);
        chk_pin("level", {11'h0, lvl}, {11'h0, seen_level});
        chk_pin("analog", ana, seen_analog);
        chk_pin("mode", {11'h0, sel > 4'h7 && sel != 4'hc}, {11'h0, out_analog_mode});
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_chk(ofspl_pkg::OFS_ENTRY, 32'h0);
        rd_chk(ofspl_pkg::OFS_SELECT, 32'h0);
        axi_wr(ofspl_pkg::OFS_SELECT, 32'h0, ofspl_pkg::RESP_SLVERR);
        axi_wr(ofspl_pkg::OFS_ENTRY, 32'd101, ofspl_pkg::RESP_OKAY);
        rd_chk(ofspl_pkg::OFS_SELECT, 32'h8);
        rd_chk(ofspl_pkg::OFS_CODE, 32'h65);
        rd_chk(ofspl_pkg::OFS_THRESH, 32'h3e8);
        rd_chk(ofspl_pkg::OFS_LOCK, 32'h0);
        axi_rd(ofspl_pkg::OFS_STATUS, ofspl_pkg::RESP_OKAY);
        chk_reg("ext adv", 32'h1, {30'h0, rd[15:14]});
        chk_pin("open pins", 12'h1, {10'h0, adv_access_open, ext_access_open});
        axi_wr(ofspl_pkg::OFS_ENTRY, 32'd201, ofspl_pkg::RESP_OKAY);
        axi_rd(ofspl_pkg::OFS_STATUS, ofspl_pkg::RESP_OKAY);
        chk_reg("ext adv", 32'h2, {30'h0, rd[15:14]});
        chk_pin("open pins", 12'h2, {10'h0, adv_access_open, ext_access_open});
        axi_wr(ofspl_pkg::OFS_THRESH, 32'd600, ofspl_pkg::RESP_OKAY);
        drive <= '{1'b0, 1'b1, 1'b0, 1'b1, 16'd0, 16'd1000, 16'd1000, 16'd1000, 16'd400, 16'd500};
        fbus <= '{16'h0200, 16'h0123};
        for (int i = 0; i < 8; i++) pin_chk(i[3:0], ~8'h97 >> i, 12'h0);
        drive <= '{1'b1, 1'b0, 1'b1, 1'b0, 16'd600, 16'd1000, 16'd300, 16'd1000, 16'd400, 16'd500};
        for (int i = 0; i < 8; i++) pin_chk(i[3:0], 8'h97 >> i, 12'h0);
        pin_chk(4'h8, 1'b0, 12'(600 * 4095 / 1000));
        drive.speed_dhz <= 16'd1000;
        pin_chk(4'h8, 1'b0, 12'hfff);
        pin_chk(4'h9, 1'b0, 12'(300 * 4095 / 2000));
        pin_chk(4'ha, 1'b0, 12'(500 * 4095 / 2000));
        pin_chk(4'hb, 1'b0, 12'(400 * 4095 / 2000));
        pin_chk(4'hc, 1'b1, 12'h0);
        pin_chk(4'hd, 1'b0, 12'h123);
        axi_wr(ofspl_pkg::OFS_SELECT, 32'he, ofspl_pkg::RESP_SLVERR);
        axi_wr(ofspl_pkg::OFS_THRESH, 32'd2001, ofspl_pkg::RESP_SLVERR);
        axi_wr(ofspl_pkg::OFS_CODE, 32'd10000, ofspl_pkg::RESP_SLVERR);
        rd_chk(ofspl_pkg::OFS_SELECT, 32'hd);
        rd_chk(ofspl_pkg::OFS_THRESH, 32'd600);
        axi_wr(ofspl_pkg::OFS_LOCK, 32'h1, ofspl_pkg::RESP_OKAY);
        axi_wr(ofspl_pkg::OFS_SELECT, 32'h0, ofspl_pkg::RESP_SLVERR);
        rd_chk(ofspl_pkg::OFS_SELECT, 32'hd);
        axi_wr(ofspl_pkg::OFS_LOCK, 32'h0, ofspl_pkg::RESP_OKAY);
        axi_wr(8'h20, 32'h0, ofspl_pkg::RESP_DECERR);
        axi_rd(8'h20, ofspl_pkg::RESP_DECERR);
        axi_wr(ofspl_pkg::OFS_CODE, 32'd5, ofspl_pkg::RESP_OKAY);
        rd_chk(ofspl_pkg::OFS_SELECT, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
